// [rtl/hbg_pkg.sv]
// Shared constants and types for the external H-bridge gate control
package hbg_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SINK_MIN_NS   = 32000;
  localparam int unsigned SINK_MAX_NS   = 64000;
  localparam int unsigned SINK_CYC      = (SINK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SINK_MAX_CYC  = SINK_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned DS_SETTLE_NS  = 1000;
  localparam int unsigned DS_FILTER_NS  = 6000;
  localparam int unsigned DS_SETTLE_CYC = (DS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DS_FILT_CYC   = (DS_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWM_MIN_HIGH_NS = 250;
  localparam int unsigned SLEW_W        = 5;
  localparam int unsigned THR_W         = 3;
  localparam int unsigned SLEW_STEPS    = 31;
  localparam int unsigned NUM_BRIDGES   = 2;
  localparam int unsigned GATES_PER_BR  = 4;
  localparam int unsigned GATE_HIGH_ONE = 0;
  localparam int unsigned GATE_LOW_ONE  = 1;
  localparam int unsigned GATE_HIGH_TWO = 2;
  localparam int unsigned GATE_LOW_TWO  = 3;

  typedef enum logic [1:0] {
    HBG_G_LOW,
    HBG_G_HIGH,
    HBG_G_SINK,
    HBG_G_RES
  } hbg_gate_t;

  typedef enum logic [1:0] {
    HBG_S_RUN,
    HBG_S_SINK,
    HBG_S_RES
  } hbg_seq_t;

  typedef struct packed {
    logic              bridge_enable_bit;
    logic              dual_leg_mode_bit;
    logic              bridge_direction_bit;
    logic              freewheel_side_leg1;
    logic              freewheel_style_leg1;
    logic              freewheel_side_leg2;
    logic              freewheel_style_leg2;
    logic [SLEW_W-1:0] slew_code;
    logic [THR_W-1:0]  short_threshold;
  } hbg_cfg_t;

  typedef struct packed {
    hbg_gate_t low_gate_two;
    hbg_gate_t high_gate_two;
    hbg_gate_t low_gate_one;
    hbg_gate_t high_gate_one;
  } hbg_gates_t;
endpackage

// [rtl/hbg_ds_mon.sv]
// Drain-source short monitor for one external MOSFET
`timescale 1ns/1ps
module hbg_ds_mon #(
  parameter int unsigned SETTLE_CYC = hbg_pkg::DS_SETTLE_CYC,
  parameter int unsigned FILT_CYC   = hbg_pkg::DS_FILT_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic gate_on,
  input  wire logic ds_cmp,
  input  wire logic flag_clear,
  output logic      short_monitor_flag,
  output logic      off_req
);
  logic [15:0] settle_cnt_r;
  logic [15:0] filt_cnt_r;
  logic        trip;

  // Counters only run while the gate is on
  always_ff @(posedge clk) begin
    if (rst || !gate_on) begin
      settle_cnt_r <= 16'h0000;
    end else if (settle_cnt_r != 16'(SETTLE_CYC)) begin
      settle_cnt_r <= settle_cnt_r + 16'h0001;
    end
  end

  // Filter may start during settling
  always_ff @(posedge clk) begin
    if (rst || !gate_on || !ds_cmp) begin
      filt_cnt_r <= 16'h0000;
    end else if (filt_cnt_r != 16'(FILT_CYC)) begin
      filt_cnt_r <= filt_cnt_r + 16'h0001;
    end
  end

  assign trip = gate_on && ds_cmp && (filt_cnt_r == 16'(FILT_CYC))
                && (settle_cnt_r == 16'(SETTLE_CYC));

  // Set wins over clear so a trip is never lost
  always_ff @(posedge clk) begin
    if (rst) begin
      short_monitor_flag <= 1'b0;
    end else if (trip) begin
      short_monitor_flag <= 1'b1;
    end else if (flag_clear) begin
      short_monitor_flag <= 1'b0;
    end
  end

  // Trip acts at once so the gate is not held past the filter time
  assign off_req = short_monitor_flag || trip;

  trip_flag_a: assert property (@(posedge clk) disable iff (rst) trip |=> short_monitor_flag)
    else $error("short flag not set after trip");

  flag_hold_a: assert property (@(posedge clk) disable iff (rst)
    short_monitor_flag && !flag_clear |=> short_monitor_flag)
    else $error("short flag dropped without clear");

  flag_cause_a: assert property (@(posedge clk) disable iff (rst)
    $rose(short_monitor_flag) |-> $past(gate_on) && $past(ds_cmp))
    else $error("short flag set while gate off or comparator low");
endmodule

// [rtl/hbg_rl_seq.sv]
// Resistive-low entry sequencer for one bridge
`timescale 1ns/1ps
module hbg_rl_seq #(
  parameter int unsigned SINK_CYC = hbg_pkg::SINK_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       fault,
  input  wire logic       hold_res,
  output hbg_pkg::hbg_seq_t seq_state
);
  logic [11:0] cnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_state <= hbg_pkg::HBG_S_RES;
    end else begin
      case (seq_state)
        hbg_pkg::HBG_S_RUN: begin
          if (hold_res) begin
            seq_state <= hbg_pkg::HBG_S_RES;
          end else if (fault) begin
            seq_state <= hbg_pkg::HBG_S_SINK;
          end
        end
        hbg_pkg::HBG_S_SINK: begin
          if (hold_res || cnt_r == 12'(SINK_CYC - 1)) begin
            seq_state <= hbg_pkg::HBG_S_RES;
          end
        end
        hbg_pkg::HBG_S_RES: begin
          if (!hold_res && !fault) begin
            seq_state <= hbg_pkg::HBG_S_RUN;
          end
        end
        default: seq_state <= hbg_pkg::HBG_S_RES;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || seq_state != hbg_pkg::HBG_S_SINK) begin
      cnt_r <= 12'h000;
    end else begin
      cnt_r <= cnt_r + 12'h001;
    end
  end

  sink_len_a: assert property (@(posedge clk) disable iff (rst)
    seq_state == hbg_pkg::HBG_S_SINK && $past(seq_state) == hbg_pkg::HBG_S_RUN && !hold_res
    |-> (seq_state == hbg_pkg::HBG_S_SINK) [*8])
    else $error("sink phase ended too early");

  sink_end_a: assert property (@(posedge clk) disable iff (rst)
    $past(seq_state) == hbg_pkg::HBG_S_SINK && seq_state == hbg_pkg::HBG_S_RES && !$past(hold_res)
    |-> $past(cnt_r) == 12'(SINK_CYC - 1))
    else $error("sink phase length wrong");
endmodule

// [rtl/hbg_ctrl.sv]
// Gate-state control for two external MOSFET H-bridges
//
// Contract
// - Single mode: PWM one high drives H2/L1 (direction 0) or H1/L2 (direction 1).
// - Single mode: side and style bits pick one of four freewheel behaviours.
// - PWM low, style 0: side 0 both low gates on, side 1 both high gates.
// - PWM low, style 1: one gate on, chosen by side and direction.
// - Charge pump low or thermal shutdown: resistive-low; overvoltage alone: actively low.
// - Drain-source short switches off only the half bridge containing it.
// - Dual mode: legs run independently from own PWM and freewheel bits.
// - Dual mode leg decoding by side and style bits against PWM level.
// - Watchdog long open window forces all drivers off.
// - Slew on: high gate uses current source while drain-source voltage is low.
// - Gate current is slew code times maximum current over 31.
// - Slew code zero disables slew control.
// - Standby, thermal, pump low, invalid command put bridges resistive.
// - Fault entry sinks 32 to 64 us before going resistive.
// - Long drain-source overvoltage switches the gate off and sets its flag.
// - Tripped gate stays off until the host clears its flag.
// - Monitoring only while gate on; gate on no longer than filter time.
// - Comparator valid after settling, but may start the filter earlier.
// - Short threshold is set separately for bridge A and bridge B.
`timescale 1ns/1ps
module hbg_ctrl #(
  parameter int unsigned SETTLE_CYC = hbg_pkg::DS_SETTLE_CYC,
  parameter int unsigned FILT_CYC   = hbg_pkg::DS_FILT_CYC,
  parameter int unsigned SINK_CYC   = hbg_pkg::SINK_CYC
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  input  hbg_pkg::hbg_cfg_t [1:0]                     cfg,
  input  wire logic [1:0]                             bridge_pwm_in_one,
  input  wire logic [1:0]                             bridge_pwm_in_two,
  input  wire logic                                   pump_voltage_low_flag,
  input  wire logic                                   thermal_shutdown_flag,
  input  wire logic                                   vs_overvoltage_flag,
  input  wire logic                                   invalid_command_flag,
  input  wire logic                                   standby_mode,
  input  wire logic                                   watchdog_long_open,
  input  wire logic [7:0]                             ds_comparator,
  input  wire logic [7:0]                             short_monitor_clear,
  input  wire logic [3:0]                             hs_vds_below_switch,
  output hbg_pkg::hbg_gates_t [1:0]                   gate_state,
  output logic [7:0]                                  short_monitor_flag_bits,
  output logic [3:0]                                  hs_slew_current_en,
  output logic [2*hbg_pkg::SLEW_W-1:0]                slew_code_out,
  output logic [2*hbg_pkg::THR_W-1:0]                 short_threshold_out
);
  hbg_pkg::hbg_gates_t gate_r   [2];
  hbg_pkg::hbg_gates_t gate_nxt [2];
  hbg_pkg::hbg_seq_t   seq_st   [2];
  logic [7:0]          ds_off;
  logic [7:0]          gate_on;
  logic                fault_rl;
  logic [1:0]          quiet;

  // Order of bits in an on-vector: {low two, high two, low one, high one}
  function automatic logic [3:0] decode_single(input hbg_pkg::hbg_cfg_t c, input logic pwm);
    logic [3:0] on;
    on = 4'h0;
    if (pwm) begin
      on = c.bridge_direction_bit ? 4'h9 : 4'h6;
    end else if (!c.freewheel_style_leg1) begin
      on = c.freewheel_side_leg1 ? 4'h5 : 4'hA;
    end else if (!c.freewheel_side_leg1) begin
      on = c.bridge_direction_bit ? 4'h8 : 4'h2;
    end else begin
      on = c.bridge_direction_bit ? 4'h1 : 4'h4;
    end
    return on;
  endfunction

  // Returns {low, high} for one leg in dual mode
  function automatic logic [1:0] decode_leg(input logic side, input logic style, input logic pwm);
    logic [1:0] on;
    on = 2'h0;
    if (!style) begin
      on = (pwm ^ side) ? 2'h1 : 2'h2;
    end else if (pwm) begin
      on = side ? 2'h2 : 2'h1;
    end
    return on;
  endfunction

  function automatic hbg_pkg::hbg_gates_t to_gates(input logic [3:0] on);
    hbg_pkg::hbg_gates_t g;
    g.high_gate_one = on[0] ? hbg_pkg::HBG_G_HIGH : hbg_pkg::HBG_G_LOW;
    g.low_gate_one  = on[1] ? hbg_pkg::HBG_G_HIGH : hbg_pkg::HBG_G_LOW;
    g.high_gate_two = on[2] ? hbg_pkg::HBG_G_HIGH : hbg_pkg::HBG_G_LOW;
    g.low_gate_two  = on[3] ? hbg_pkg::HBG_G_HIGH : hbg_pkg::HBG_G_LOW;
    return g;
  endfunction

  function automatic hbg_pkg::hbg_gates_t all_gates(input hbg_pkg::hbg_gate_t s);
    hbg_pkg::hbg_gates_t g;
    g.high_gate_one = s;
    g.low_gate_one  = s;
    g.high_gate_two = s;
    g.low_gate_two  = s;
    return g;
  endfunction

  assign fault_rl = pump_voltage_low_flag || thermal_shutdown_flag || invalid_command_flag;

  for (genvar b = 0; b < 2; b++) begin : g_br
    logic [3:0] on_vec;
    logic       drive_ok;

    hbg_rl_seq #(
      .SINK_CYC (SINK_CYC)
    ) u_seq (
      .clk       (clk),
      .rst       (rst),
      .fault     (fault_rl),
      .hold_res  (standby_mode || !cfg[b].bridge_enable_bit),
      .seq_state (seq_st[b])
    );

    for (genvar g = 0; g < 4; g++) begin : g_mon
      hbg_ds_mon #(
        .SETTLE_CYC (SETTLE_CYC),
        .FILT_CYC   (FILT_CYC)
      ) u_mon (
        .clk                (clk),
        .rst                (rst),
        .gate_on            (gate_on[b*4+g]),
        .ds_cmp             (ds_comparator[b*4+g]),
        .flag_clear         (short_monitor_clear[b*4+g]),
        .short_monitor_flag (short_monitor_flag_bits[b*4+g]),
        .off_req            (ds_off[b*4+g])
      );
    end

    assign gate_on[b*4+0] = gate_r[b].high_gate_one == hbg_pkg::HBG_G_HIGH;
    assign gate_on[b*4+1] = gate_r[b].low_gate_one == hbg_pkg::HBG_G_HIGH;
    assign gate_on[b*4+2] = gate_r[b].high_gate_two == hbg_pkg::HBG_G_HIGH;
    assign gate_on[b*4+3] = gate_r[b].low_gate_two == hbg_pkg::HBG_G_HIGH;
    assign quiet[b] = cfg[b].bridge_enable_bit && !fault_rl && !standby_mode
                      && seq_st[b] == hbg_pkg::HBG_S_RUN;
    assign drive_ok = quiet[b] && !vs_overvoltage_flag && !watchdog_long_open
                      && ds_off[b*4+3:b*4] == 4'h0;

    always_comb begin
      on_vec = 4'h0;
      if (cfg[b].dual_leg_mode_bit) begin
        on_vec[1:0] = decode_leg(cfg[b].freewheel_side_leg1, cfg[b].freewheel_style_leg1, bridge_pwm_in_one[b]);
        on_vec[3:2] = decode_leg(cfg[b].freewheel_side_leg2, cfg[b].freewheel_style_leg2, bridge_pwm_in_two[b]);
      end else begin
        on_vec = decode_single(cfg[b], bridge_pwm_in_one[b]);
      end
      // A shorted MOSFET takes its whole leg off
      if (ds_off[b*4+0] || ds_off[b*4+1]) begin
        on_vec[1:0] = 2'h0;
      end
      if (ds_off[b*4+2] || ds_off[b*4+3]) begin
        on_vec[3:2] = 2'h0;
      end
      // Priority: disable, resistive sequence, overvoltage, watchdog, decode
      if (!cfg[b].bridge_enable_bit) begin
        gate_nxt[b] = all_gates(hbg_pkg::HBG_G_RES);
      end else if (seq_st[b] == hbg_pkg::HBG_S_SINK ||
                   (seq_st[b] == hbg_pkg::HBG_S_RUN && fault_rl && !standby_mode)) begin
        gate_nxt[b] = all_gates(hbg_pkg::HBG_G_SINK);
      end else if (seq_st[b] == hbg_pkg::HBG_S_RES || standby_mode) begin
        gate_nxt[b] = all_gates(hbg_pkg::HBG_G_RES);
      end else if (vs_overvoltage_flag) begin
        gate_nxt[b] = all_gates(hbg_pkg::HBG_G_LOW);
      end else if (watchdog_long_open) begin
        gate_nxt[b] = all_gates(hbg_pkg::HBG_G_LOW);
      end else begin
        gate_nxt[b] = to_gates(on_vec);
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        gate_r[b] <= all_gates(hbg_pkg::HBG_G_RES);
      end else begin
        gate_r[b] <= gate_nxt[b];
      end
    end

    // Slew source only on the high gates, only with a non-zero code
    always_ff @(posedge clk) begin
      if (rst) begin
        hs_slew_current_en[b*2+1:b*2] <= 2'h0;
      end else begin
        hs_slew_current_en[b*2] <= (cfg[b].slew_code != 5'h00) && hs_vds_below_switch[b*2]
                                   && (gate_nxt[b].high_gate_one inside {hbg_pkg::HBG_G_HIGH, hbg_pkg::HBG_G_SINK});
        hs_slew_current_en[b*2+1] <= (cfg[b].slew_code != 5'h00) && hs_vds_below_switch[b*2+1]
                                     && (gate_nxt[b].high_gate_two inside {hbg_pkg::HBG_G_HIGH, hbg_pkg::HBG_G_SINK});
      end
    end

    // Current is code times one 1/31 step; the analog side scales it
    always_ff @(posedge clk) begin
      if (rst) begin
        slew_code_out[b*hbg_pkg::SLEW_W +: hbg_pkg::SLEW_W] <= 5'h00;
        short_threshold_out[b*hbg_pkg::THR_W +: hbg_pkg::THR_W] <= 3'h0;
      end else begin
        slew_code_out[b*hbg_pkg::SLEW_W +: hbg_pkg::SLEW_W] <= cfg[b].slew_code;
        short_threshold_out[b*hbg_pkg::THR_W +: hbg_pkg::THR_W] <= cfg[b].short_threshold;
      end
    end

    dis_res_a: assert property (@(posedge clk) disable iff (rst)
      !cfg[b].bridge_enable_bit |=> gate_r[b] == all_gates(hbg_pkg::HBG_G_RES))
      else $error("disabled bridge not resistive-low");

    ov_low_a: assert property (@(posedge clk) disable iff (rst)
      quiet[b] && vs_overvoltage_flag |=> gate_r[b] == all_gates(hbg_pkg::HBG_G_LOW))
      else $error("overvoltage did not force gates low");

    wd_off_a: assert property (@(posedge clk) disable iff (rst)
      quiet[b] && watchdog_long_open |=> gate_r[b] == all_gates(hbg_pkg::HBG_G_LOW))
      else $error("long open window did not force gates off");

    fault_sink_a: assert property (@(posedge clk) disable iff (rst)
      cfg[b].bridge_enable_bit && seq_st[b] == hbg_pkg::HBG_S_RUN && pump_voltage_low_flag && !standby_mode
      |=> gate_r[b] == all_gates(hbg_pkg::HBG_G_SINK) ##1 gate_r[b] == all_gates(hbg_pkg::HBG_G_SINK))
      else $error("fault entry did not sink");

    single_drive_a: assert property (@(posedge clk) disable iff (rst)
      quiet[b] && !vs_overvoltage_flag && !watchdog_long_open && !cfg[b].dual_leg_mode_bit
      && bridge_pwm_in_one[b] && !cfg[b].bridge_direction_bit && ds_off[b*4+3:b*4] == 4'h0
      |=> gate_on[b*4+3:b*4] == 4'h6)
      else $error("single mode drive decode wrong");

    single_rev_a: assert property (@(posedge clk) disable iff (rst)
      drive_ok && !cfg[b].dual_leg_mode_bit && bridge_pwm_in_one[b] && cfg[b].bridge_direction_bit
      |=> gate_on[b*4+3:b*4] == 4'h9)
      else $error("single mode reverse drive wrong");

    fw_low_a: assert property (@(posedge clk) disable iff (rst)
      drive_ok && !cfg[b].dual_leg_mode_bit && !bridge_pwm_in_one[b] && !cfg[b].freewheel_style_leg1
      && !cfg[b].freewheel_side_leg1 |=> gate_on[b*4+3:b*4] == 4'hA)
      else $error("active low freewheel wrong");

    fw_high_a: assert property (@(posedge clk) disable iff (rst)
      drive_ok && !cfg[b].dual_leg_mode_bit && !bridge_pwm_in_one[b] && !cfg[b].freewheel_style_leg1
      && cfg[b].freewheel_side_leg1 |=> gate_on[b*4+3:b*4] == 4'h5)
      else $error("active high freewheel wrong");

    pass_low_a: assert property (@(posedge clk) disable iff (rst)
      drive_ok && !cfg[b].dual_leg_mode_bit && !bridge_pwm_in_one[b] && cfg[b].freewheel_style_leg1
      && !cfg[b].freewheel_side_leg1
      |=> gate_on[b*4+3:b*4] == ($past(cfg[b].bridge_direction_bit) ? 4'h8 : 4'h2))
      else $error("passive low freewheel wrong");

    pass_high_a: assert property (@(posedge clk) disable iff (rst)
      drive_ok && !cfg[b].dual_leg_mode_bit && !bridge_pwm_in_one[b] && cfg[b].freewheel_style_leg1
      && cfg[b].freewheel_side_leg1
      |=> gate_on[b*4+3:b*4] == ($past(cfg[b].bridge_direction_bit) ? 4'h1 : 4'h4))
      else $error("passive high freewheel wrong");

    leg_drive_a: assert property (@(posedge clk) disable iff (rst)
      drive_ok && cfg[b].dual_leg_mode_bit && !cfg[b].freewheel_style_leg1 && !cfg[b].freewheel_side_leg1
      && bridge_pwm_in_one[b] |=> gate_on[b*4+1:b*4] == 2'h1)
      else $error("dual leg high drive wrong");

    leg_low_a: assert property (@(posedge clk) disable iff (rst)
      drive_ok && cfg[b].dual_leg_mode_bit && !cfg[b].freewheel_style_leg2 && cfg[b].freewheel_side_leg2
      && bridge_pwm_in_two[b] |=> gate_on[b*4+3:b*4+2] == 2'h2)
      else $error("dual leg low drive wrong");

    leg_pass_a: assert property (@(posedge clk) disable iff (rst)
      drive_ok && cfg[b].dual_leg_mode_bit && cfg[b].freewheel_style_leg1 && !bridge_pwm_in_one[b]
      |=> gate_on[b*4+1:b*4] == 2'h0)
      else $error("dual leg passive freewheel wrong");

    short_leg_a: assert property (@(posedge clk) disable iff (rst)
      ds_off[b*4+2] || ds_off[b*4+3] |=> gate_on[b*4+3:b*4+2] == 2'h0)
      else $error("shorted leg still driven");

    standby_res_a: assert property (@(posedge clk) disable iff (rst)
      cfg[b].bridge_enable_bit && standby_mode && seq_st[b] != hbg_pkg::HBG_S_SINK
      |=> gate_r[b] == all_gates(hbg_pkg::HBG_G_RES))
      else $error("standby not resistive");

    res_hold_a: assert property (@(posedge clk) disable iff (rst)
      cfg[b].bridge_enable_bit && seq_st[b] == hbg_pkg::HBG_S_RES
      |=> gate_r[b] == all_gates(hbg_pkg::HBG_G_RES))
      else $error("resistive state not shown");

    fault_prio_a: assert property (@(posedge clk) disable iff (rst)
      cfg[b].bridge_enable_bit && seq_st[b] == hbg_pkg::HBG_S_RUN && fault_rl && !standby_mode
      |=> gate_on[b*4+3:b*4] == 4'h0)
      else $error("fault did not override decode");

    slew_zero_a: assert property (@(posedge clk) disable iff (rst)
      cfg[b].slew_code == 5'h00 |=> hs_slew_current_en[b*2+1:b*2] == 2'h0)
      else $error("slew source on with zero code");

    slew_vds_a: assert property (@(posedge clk) disable iff (rst)
      hs_vds_below_switch[b*2+1:b*2] == 2'h0 |=> hs_slew_current_en[b*2+1:b*2] == 2'h0)
      else $error("slew source on above switch threshold");

    slew_code_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> slew_code_out[b*hbg_pkg::SLEW_W +: hbg_pkg::SLEW_W] == $past(cfg[b].slew_code))
      else $error("slew code not passed");

    thr_sel_a: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> short_threshold_out[b*hbg_pkg::THR_W +: hbg_pkg::THR_W] == $past(cfg[b].short_threshold))
      else $error("short threshold not passed");
  end

  assign gate_state[0] = gate_r[0];
  assign gate_state[1] = gate_r[1];
endmodule

// [test/hbg_host.sv]
// Host model that drives the bridge PWM pins
`timescale 1ns/1ps
module hbg_host #(
  parameter int unsigned MIN_HIGH = 13
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] pwm_req,
  output logic      [1:0] pwm_one,
  output logic      [1:0] pwm_two
);
  logic [3:0] pin_r;
  int         high_cnt [4];

  assign pwm_one = {pin_r[1], pin_r[0]};
  assign pwm_two = {pin_r[3], pin_r[2]};

  // A requested low waits until the pulse is long enough; 13 cycles keep it above 250 ns
  always @(negedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (rst) begin
        pin_r[i]    <= 1'b0;
        high_cnt[i] <= 0;
      end else if (pin_r[i] && (pwm_req[i] || high_cnt[i] < MIN_HIGH)) begin
        high_cnt[i] <= high_cnt[i] + 1;
      end else begin
        pin_r[i]    <= pwm_req[i];
        high_cnt[i] <= pwm_req[i] ? 1 : 0;
      end
    end
  end
endmodule

// [test/hbg_ctrl_bench.sv]
// Self-checking bench for the H-bridge gate control
`timescale 1ns/1ps
module hbg_ctrl_bench;
  localparam int unsigned FILT = 8;
  localparam int unsigned SINK = 10;
  logic                      clk;
  logic                      rst;
  hbg_pkg::hbg_cfg_t [1:0]   cfg;
  logic [3:0]                pwm_req;
  logic [1:0]                pwm_one;
  logic [1:0]                pwm_two;
  logic [2:0]                flt;
  logic                      overvolt;
  logic                      standby;
  logic                      wd_open;
  logic [7:0]                ds_cmp;
  logic [7:0]                ds_clr;
  logic [3:0]                vds_below;
  hbg_pkg::hbg_gates_t [1:0] gates;
  logic [7:0]                flags;
  logic [3:0]                slew_en;
  logic [9:0]                slew_out;
  logic [5:0]                thr_out;
  int                        fails;
  int                        total_checks;

  hbg_host hbg_host_i (.clk(clk), .rst(rst), .pwm_req(pwm_req), .pwm_one(pwm_one), .pwm_two(pwm_two));

  hbg_ctrl #(.SETTLE_CYC(4), .FILT_CYC(FILT), .SINK_CYC(SINK)) hbg_ctrl_i (
    .clk(clk), .rst(rst), .cfg(cfg), .bridge_pwm_in_one(pwm_one), .bridge_pwm_in_two(pwm_two),
    .pump_voltage_low_flag(flt[2]), .thermal_shutdown_flag(flt[1]), .vs_overvoltage_flag(overvolt),
    .invalid_command_flag(flt[0]), .standby_mode(standby), .watchdog_long_open(wd_open),
    .ds_comparator(ds_cmp), .short_monitor_clear(ds_clr), .hs_vds_below_switch(vds_below),
    .gate_state(gates), .short_monitor_flag_bits(flags), .hs_slew_current_en(slew_en),
    .slew_code_out(slew_out), .short_threshold_out(thr_out));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    if (fails == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  function automatic hbg_pkg::hbg_gate_t lv(input logic on);
    return on ? hbg_pkg::HBG_G_HIGH : hbg_pkg::HBG_G_LOW;
  endfunction

  // Bits are {high one, low one, high two, low two}
  function automatic logic [7:0] mk(input logic [3:0] p);
    return {lv(p[0]), lv(p[1]), lv(p[2]), lv(p[3])};
  endfunction

  // Index bits are {pwm, style, side, direction}
  function automatic logic [7:0] single_exp(input logic [3:0] i);
    if (i[3]) return i[0] ? mk(4'b1001) : mk(4'b0110);
    if (!i[2]) return i[1] ? mk(4'b1010) : mk(4'b0101);
    if (!i[1]) return i[0] ? mk(4'b0001) : mk(4'b0100);
    return i[0] ? mk(4'b1000) : mk(4'b0010);
  endfunction

  // Index bits are {pwm, style, side}; result is {high, low}
  function automatic logic [1:0] leg_exp(input logic [2:0] i);
    if (!i[1]) return (i[2] ^ i[0]) ? 2'b10 : 2'b01;
    return !i[2] ? 2'b00 : (i[0] ? 2'b01 : 2'b10);
  endfunction

  // Bridge A driving H2/L1, bridge B disabled, no faults
  task automatic drive_a();
    cfg = '0;
    cfg[0].bridge_enable_bit = 1'b1;
    pwm_req <= 4'h1;
    {flt, overvolt, standby, wd_open} = '0;
    settle(16);
  endtask

  task automatic single_mode();
    for (int i = 0; i < 16; i++) begin
      cfg = '0;
      cfg[0].bridge_enable_bit    = 1'b1;
      cfg[0].bridge_direction_bit = i[0];
      cfg[0].freewheel_side_leg1  = i[1];
      cfg[0].freewheel_style_leg1 = i[2];
      cfg[0].freewheel_side_leg2  = ~i[1];
      pwm_req <= {1'b0, ~i[3], 1'b0, i[3]};
      settle(16);
      check({gates[1], gates[0]}, {8'hFF, single_exp(4'(i))});
    end
  endtask

  task automatic dual_mode();
    logic [2:0] a;
    logic [2:0] b;
    for (int i = 0; i < 8; i++) begin
      a = 3'(i);
      b = 3'(7 - i);
      cfg = '0;
      cfg[1].bridge_enable_bit    = 1'b1;
      cfg[1].dual_leg_mode_bit    = 1'b1;
      cfg[1].bridge_direction_bit = a[0];
      {cfg[1].freewheel_style_leg1, cfg[1].freewheel_side_leg1} = a[1:0];
      {cfg[1].freewheel_style_leg2, cfg[1].freewheel_side_leg2} = b[1:0];
      pwm_req <= {b[2], 1'b0, a[2], 1'b0};
      settle(16);
      check({gates[1], gates[0]}, {mk({leg_exp(a), leg_exp(b)}), 8'hFF});
    end
  endtask

  task automatic faults();
    int n;
    drive_a();
    overvolt = 1'b1;
    settle(3);
    check(gates[0], 8'h00);
    overvolt = 1'b0;
    wd_open  = 1'b1;
    settle(3);
    check(gates[0], 8'h00);
    wd_open = 1'b0;
    standby = 1'b1;
    settle(3);
    check(gates[0], 8'hFF);
    standby = 1'b0;
    cfg[0].bridge_enable_bit = 1'b0;
    settle(3);
    check(gates[0], 8'hFF);
    for (int k = 0; k < 3; k++) begin
      drive_a();
      check(gates[0], mk(4'b0110));
      flt = 3'b100 >> k;
      n   = 0;
      while (gates[0] !== 8'hAA && n < 4) begin
        settle(1);
        n++;
      end
      check(gates[0], 8'hAA);
      n = 0;
      while (gates[0] === 8'hAA && n < 40) begin
        settle(1);
        n++;
      end
      check(n >= SINK && n <= 2 * SINK, 1'b1);
      check(gates[0], 8'hFF);
    end
  endtask

  task automatic short_trip();
    int n;
    drive_a();
    ds_cmp[2] = 1'b1;
    n = 0;
    while (flags !== 8'h04 && n < 30) begin
      settle(1);
      n++;
    end
    check(n >= FILT && n <= FILT + 3, 1'b1);
    settle(2);
    check(gates[0], mk(4'b0100));
    ds_cmp[2] = 1'b0;
    settle(6);
    check({flags, gates[0]}, {8'h04, mk(4'b0100)});
    ds_clr[2] = 1'b1;
    settle(1);
    ds_clr[2] = 1'b0;
    settle(4);
    check({flags, gates[0]}, {8'h00, mk(4'b0110)});
  endtask

  task automatic slew_thr();
    drive_a();
    cfg[0].slew_code       = 5'h0B;
    cfg[1].slew_code       = 5'h1F;
    cfg[0].short_threshold = 3'h5;
    cfg[1].short_threshold = 3'h2;
    vds_below = 4'hF;
    settle(3);
    check({slew_en, slew_out, thr_out}, {4'h2, 5'h1F, 5'h0B, 3'h2, 3'h5});
    vds_below = 4'h0;
    settle(3);
    check(slew_en, 4'h0);
    vds_below        = 4'hF;
    cfg[0].slew_code = 5'h00;
    settle(3);
    check(slew_en, 4'h0);
  endtask

  initial begin
    fails        = 0;
    total_checks = 0;
    rst          = 1'b1;
    cfg          = '0;
    pwm_req      = 4'h0;
    {flt, overvolt, standby, wd_open} = '0;
    ds_cmp       = 8'h00;
    ds_clr       = 8'h00;
    vds_below    = 4'h0;
    settle(8);
    check({flags, gates[1], gates[0]}, 24'h00FFFF);
    rst = 1'b0;
    single_mode();
    dual_mode();
    faults();
    short_trip();
    slew_thr();
    give_verdict();
  end
endmodule
